// ===== wse_setpoint.sv
// module: one weight setpoint with trip logic, anticipation and done actions
`timescale 1ns/1ps

module wse_setpoint
  import wse_pkg::*;
#(
  parameter int WIDTH       = wse_pkg::WEIGHT_W,
  parameter int SETTLE_UNIT = wse_pkg::SETTLE_UNIT_CYC
)
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [7:0]               regAddr,
  input  wire logic [31:0]              regWdata,
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  output logic [31:0]                   regRdata,
  input  wire logic signed [WIDTH-1:0]  weightSample,
  input  wire logic                     sampleValid,
  input  wire logic                     standstill,
  output logic                          outputSelectN,
  output logic                          accumulatePulse,
  output logic                          printPulse,
  output logic                          tarePulse,
  output logic                          stepDone
);

  initial
  begin
    if (WIDTH < 8 || WIDTH > 32)
      $error("wse_setpoint: WIDTH out of range");
    if (SETTLE_UNIT < 1)
      $error("wse_setpoint: SETTLE_UNIT must be positive");
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [17:0]             ctrl_reg;
  logic signed [WIDTH-1:0] value_reg;
  logic signed [WIDTH-1:0] hyst_reg;
  logic signed [WIDTH-1:0] band_reg;
  logic signed [WIDTH-1:0] antic_reg;
  logic signed [WIDTH-1:0] antic_next;
  logic [PCT_W-1:0]        corrPct_reg;
  logic [TMO_W-1:0]        settleTmo_reg;
  logic [CNT_W-1:0]        learnInt_reg;
  logic signed [WIDTH-1:0] skew_reg;
  logic signed [WIDTH-1:0] refTab_reg [NUM_SP];

  wse_trip_e  trip;
  wse_antic_e anticMode;
  wse_kind_e  kind;
  wse_acc_e   accMode;
  wse_prn_e   prnMode;
  logic       batchMode;
  logic       tareEn;
  logic       spEnable;
  logic [IDX_W-1:0] refIdx;

  assign trip      = wse_trip_e'(ctrl_reg[CTRL_TRIP_LSB +: 2]);
  assign anticMode = wse_antic_e'(ctrl_reg[CTRL_ANT_LSB +: 2]);
  assign kind      = wse_kind_e'(ctrl_reg[CTRL_KIND_LSB +: 3]);
  assign accMode   = wse_acc_e'(ctrl_reg[CTRL_ACC_LSB +: 2]);
  assign prnMode   = wse_prn_e'(ctrl_reg[CTRL_PRN_LSB +: 2]);
  assign batchMode = ctrl_reg[CTRL_BATCH_BIT];
  assign tareEn    = ctrl_reg[CTRL_TARE_BIT];
  assign spEnable  = ctrl_reg[CTRL_EN_BIT];
  assign refIdx    = ctrl_reg[CTRL_REF_LSB +: IDX_W];

  logic wrCtrl;
  logic wrRef;
  logic startReq;
  assign wrCtrl   = regWrite && (regAddr == ADDR_CTRL);
  assign wrRef    = regWrite && (regAddr[7:5] == ADDR_REFTAB[7:5]);
  assign startReq = wrCtrl && regWdata[CTRL_START_BIT];
  // start is judged against the control word being written, not the old one
  logic startBatch;
  assign startBatch = startReq && regWdata[CTRL_BATCH_BIT] && regWdata[CTRL_EN_BIT];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg      <= '0;
      value_reg     <= '0;
      hyst_reg      <= '0;
      band_reg      <= '0;
      corrPct_reg   <= RST_CORR_PCT;
      settleTmo_reg <= RST_SETTLE;
      learnInt_reg  <= RST_ADAPTIVE_LEARNING_INT;
      skew_reg      <= WIDTH'(RST_SKEW);
    end
    else if (regWrite)
    begin
      case (regAddr)
        ADDR_CTRL:  ctrl_reg  <= {1'b0, regWdata[16:0]};
        ADDR_VALUE: value_reg <= regWdata[WIDTH-1:0];
        ADDR_HYST:  hyst_reg  <= regWdata[WIDTH-1:0];
        ADDR_BAND:  band_reg  <= regWdata[WIDTH-1:0];
        ADDR_SKEW:  skew_reg  <= regWdata[WIDTH-1:0];
        ADDR_TUNE:
        begin
          corrPct_reg   <= regWdata[TUNE_PCT_LSB +: PCT_W];
          settleTmo_reg <= regWdata[TUNE_TMO_LSB +: TMO_W];
          learnInt_reg  <= regWdata[TUNE_CNT_LSB +: CNT_W];
        end
        default: ;
      endcase
    end
  end

  // reference table holds the values of the other setpoints
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < NUM_SP; i++)
        refTab_reg[i] <= '0;
    else if (wrRef)
      refTab_reg[regAddr[4:2]] <= regWdata[WIDTH-1:0];
  end

  // ************************************************************
  // target and trip evaluation
  // ************************************************************
  logic signed [WIDTH-1:0] target;

  wse_target_calc #(.WIDTH(WIDTH)) u_target
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .kind     (kind),
    .ownValue (value_reg),
    .refValue (refTab_reg[refIdx]),
    .target   (target)
  );

  logic signed [WIDTH-1:0] prevWeight_reg;
  logic signed [WIDTH-1:0] rate_reg;
  logic signed [WIDTH-1:0] lead;
  logic signed [WIDTH-1:0] tripVal;
  logic signed [WIDTH-1:0] projected;
  logic                    rising;
  logic                    rawMet;
  logic                    inBandHit;
  logic                    armed_reg;
  logic                    met;

  assign rising = (trip != WSE_TRIP_LOWER);
  assign projected = weightSample + ((anticMode == WSE_ANT_FLOW) ? rate_reg : '0);
  assign lead = (anticMode == WSE_ANT_FIXED || anticMode == WSE_ANT_ADAPTIVE_LEARNING) ? antic_reg : '0;
  assign tripVal = rising ? target - lead : target + lead;
  assign inBandHit = (weightSample >= target - band_reg) && (weightSample <= target + band_reg);

  assign rawMet = (trip == WSE_TRIP_HIGHER) ? (projected >= tripVal) :
                  (trip == WSE_TRIP_LOWER)  ? (projected <= tripVal) :
                  (trip == WSE_TRIP_INBAND) ? inBandHit : !inBandHit;
  assign met = rawMet && armed_reg;

  logic outsideHyst;
  assign outsideHyst = rising ? (weightSample < target - hyst_reg) : (weightSample > target + hyst_reg);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_reg      <= 1'b1;
      prevWeight_reg <= '0;
      rate_reg       <= '0;
    end
    else if (sampleValid)
    begin
      prevWeight_reg <= weightSample;
      rate_reg       <= weightSample - prevWeight_reg;
      if (!rawMet && outsideHyst)
        armed_reg <= 1'b1;
      else if (rawMet && !batchMode)
        armed_reg <= 1'b0;
    end
  end

  // ************************************************************
  // batch sequencing and anticipation learning
  // ************************************************************
  wse_state_e state_reg;
  wse_state_e state_next;
  logic [31:0]      unitCnt_reg;
  logic [TMO_W-1:0] tenthCnt_reg;
  logic [CNT_W-1:0] batchCnt_reg;
  logic             prnWait_reg;
  logic             tick;
  logic             settleExpired;
  logic signed [WIDTH-1:0]   err;
  logic signed [WIDTH+8:0]   corr;
  logic                      errUsable;
  logic                      recalcDue;

  assign tick          = (unitCnt_reg == 32'(SETTLE_UNIT - 1));
  assign settleExpired = (tenthCnt_reg >= settleTmo_reg);
  // error from the last valid sample; the weight pins are not held between samples
  assign err           = rising ? prevWeight_reg - target : target - prevWeight_reg;
  assign corr = ((WIDTH+9)'(err) * (WIDTH+9)'(signed'({1'b0, corrPct_reg}))) / (WIDTH+9)'(100);
  assign errUsable = (skew_reg == '0) || ((err <= skew_reg) && (err >= -skew_reg));
  assign recalcDue = (batchCnt_reg + 8'h01 >= learnInt_reg);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      WSE_ST_IDLE:   if (startBatch) state_next = WSE_ST_FEED;
      WSE_ST_FEED:   if (sampleValid && met) state_next = WSE_ST_SETTLE;
      WSE_ST_SETTLE:
      begin
        if (standstill)
          state_next = WSE_ST_ADJUST;
        else if (settleExpired)
          state_next = WSE_ST_DONE;
      end
      WSE_ST_ADJUST: state_next = WSE_ST_DONE;
      WSE_ST_DONE:   state_next = WSE_ST_IDLE;
      default:       state_next = WSE_ST_IDLE;
    endcase
  end

  always_comb
  begin
    antic_next = antic_reg;
    if (state_reg == WSE_ST_ADJUST && anticMode == WSE_ANT_ADAPTIVE_LEARNING && recalcDue && errUsable)
      antic_next = antic_reg + corr[WIDTH-1:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg    <= WSE_ST_IDLE;
      unitCnt_reg  <= '0;
      tenthCnt_reg <= '0;
      batchCnt_reg <= '0;
      antic_reg    <= '0;
    end
    else
    begin
      state_reg   <= state_next;
      unitCnt_reg <= (state_reg != WSE_ST_SETTLE || tick) ? '0 : unitCnt_reg + 32'd1;
      if (state_reg != WSE_ST_SETTLE)
        tenthCnt_reg <= '0;
      else if (tick)
        tenthCnt_reg <= tenthCnt_reg + 16'd1;
      if (regWrite && regAddr == ADDR_ANTIC)
        antic_reg <= regWdata[WIDTH-1:0];
      else
        antic_reg <= antic_next;
      if (state_reg == WSE_ST_ADJUST || (state_reg == WSE_ST_SETTLE && state_next == WSE_ST_DONE))
        batchCnt_reg <= recalcDue ? '0 : batchCnt_reg + 8'h01;
    end
  end

  // ************************************************************
  // done actions and output
  // ************************************************************
  logic satisfied;
  assign satisfied = batchMode ? (state_reg == WSE_ST_FEED && state_next == WSE_ST_SETTLE)
                               : (sampleValid && met && spEnable);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      accumulatePulse <= 1'b0;
      printPulse      <= 1'b0;
      tarePulse       <= 1'b0;
      prnWait_reg     <= 1'b0;
      stepDone        <= 1'b0;
      outputSelectN   <= 1'b1;
      regRdata        <= '0;
    end
    else
    begin
      accumulatePulse <= satisfied && (accMode != WSE_ACC_OFF);
      printPulse <= (satisfied && (prnMode == WSE_PRN_ON || accMode == WSE_ACC_ON)) ||
                    (prnWait_reg && standstill);
      if (satisfied && prnMode == WSE_PRN_WAIT)
        prnWait_reg <= 1'b1;
      else if (standstill)
        prnWait_reg <= 1'b0;
      tarePulse <= satisfied && tareEn;
      stepDone  <= (state_reg == WSE_ST_DONE);
      if (batchMode)
        outputSelectN <= !(state_next == WSE_ST_FEED);
      else if (sampleValid)
        outputSelectN <= !(spEnable && met);
      regRdata <= '0;
      if (regRead)
        case (regAddr)
          ADDR_CTRL:   regRdata <= 32'(ctrl_reg);
          ADDR_VALUE:  regRdata <= 32'(value_reg);
          ADDR_HYST:   regRdata <= 32'(hyst_reg);
          ADDR_BAND:   regRdata <= 32'(band_reg);
          ADDR_TUNE:   regRdata <= {learnInt_reg, settleTmo_reg, corrPct_reg};
          ADDR_SKEW:   regRdata <= 32'(skew_reg);
          ADDR_ANTIC:  regRdata <= 32'(antic_reg);
          ADDR_STATUS: regRdata <= {24'h00_0000, batchCnt_reg[3:0], armed_reg, state_reg};
          ADDR_TARGET: regRdata <= 32'(target);
          default:     regRdata <= '0;
        endcase
    end
  end

endmodule

// ===== wse_pkg.sv
// package: constants, encodings and timing counts for the weigh setpoint engine
package wse_pkg;

  // ************************************************************
  // widths and sizes
  // ************************************************************
  localparam int WEIGHT_W     = 24;
  localparam int NUM_SP       = 8;
  localparam int IDX_W        = 3;
  localparam int PCT_W        = 8;
  localparam int TMO_W        = 16;
  localparam int CNT_W        = 8;

  // ************************************************************
  // register offsets (byte address, word index = address / 4)
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_VALUE     = 8'h04;
  localparam logic [7:0] ADDR_HYST      = 8'h08;
  localparam logic [7:0] ADDR_BAND      = 8'h0C;
  localparam logic [7:0] ADDR_ANTIC     = 8'h10;
  localparam logic [7:0] ADDR_TUNE      = 8'h14;
  localparam logic [7:0] ADDR_SKEW      = 8'h18;
  localparam logic [7:0] ADDR_STATUS    = 8'h1C;
  localparam logic [7:0] ADDR_TARGET    = 8'h20;
  localparam logic [7:0] ADDR_REFTAB    = 8'h40;

  // ************************************************************
  // control register field positions
  // ************************************************************
  localparam int CTRL_TRIP_LSB  = 0;
  localparam int CTRL_ANT_LSB   = 2;
  localparam int CTRL_KIND_LSB  = 4;
  localparam int CTRL_BATCH_BIT = 7;
  localparam int CTRL_ACC_LSB   = 8;
  localparam int CTRL_PRN_LSB   = 10;
  localparam int CTRL_TARE_BIT  = 12;
  localparam int CTRL_REF_LSB   = 13;
  localparam int CTRL_EN_BIT    = 16;
  localparam int CTRL_START_BIT = 17;

  localparam int TUNE_PCT_LSB   = 0;
  localparam int TUNE_TMO_LSB   = 8;
  localparam int TUNE_CNT_LSB   = 24;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [PCT_W-1:0] RST_CORR_PCT  = 8'h32;
  localparam logic [TMO_W-1:0] RST_SETTLE    = 16'h0000;
  localparam logic [CNT_W-1:0] RST_ADAPTIVE_LEARNING_INT = 8'h01;
  localparam logic [WEIGHT_W-1:0] RST_SKEW   = 24'h00_0000;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ        = 100;
  localparam int SETTLE_UNIT_MS = 100;
  localparam int SETTLE_UNIT_CYC = SETTLE_UNIT_MS * 1000 * CLK_MHZ;

  // ************************************************************
  // encodings
  // ************************************************************
  typedef enum logic [1:0]
  {
    WSE_TRIP_HIGHER  = 2'b00,
    WSE_TRIP_LOWER   = 2'b01,
    WSE_TRIP_INBAND  = 2'b10,
    WSE_TRIP_OUTBAND = 2'b11
  } wse_trip_e;

  typedef enum logic [1:0]
  {
    WSE_ANT_OFF   = 2'b00,
    WSE_ANT_FIXED = 2'b01,
    WSE_ANT_ADAPTIVE_LEARNING = 2'b10,
    WSE_ANT_FLOW  = 2'b11
  } wse_antic_e;

  typedef enum logic [2:0]
  {
    WSE_KIND_GROSS = 3'b000,
    WSE_KIND_NET   = 3'b001,
    WSE_KIND_ADD   = 3'b010,
    WSE_KIND_SUB   = 3'b011,
    WSE_KIND_PCT   = 3'b100
  } wse_kind_e;

  typedef enum logic [1:0]
  {
    WSE_ACC_OFF   = 2'b00,
    WSE_ACC_ON    = 2'b01,
    WSE_ACC_QUIET = 2'b10
  } wse_acc_e;

  typedef enum logic [1:0]
  {
    WSE_PRN_OFF  = 2'b00,
    WSE_PRN_ON   = 2'b01,
    WSE_PRN_WAIT = 2'b10
  } wse_prn_e;

  typedef enum logic [2:0]
  {
    WSE_ST_IDLE   = 3'b000,
    WSE_ST_FEED   = 3'b001,
    WSE_ST_SETTLE = 3'b010,
    WSE_ST_ADJUST = 3'b011,
    WSE_ST_DONE   = 3'b100
  } wse_state_e;

endpackage

// ===== wse_target_calc.sv
// module: forms the target weight of a relative setpoint from its reference
`timescale 1ns/1ps
module wse_target_calc
  import wse_pkg::*;
#(
  parameter int WIDTH = wse_pkg::WEIGHT_W
)
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire wse_pkg::wse_kind_e       kind,
  input  wire logic signed [WIDTH-1:0]  ownValue,
  input  wire logic signed [WIDTH-1:0]  refValue,
  output logic signed [WIDTH-1:0]       target
);

  initial
  begin
    if (WIDTH < 8 || WIDTH > 48)
      $error("wse_target_calc: WIDTH out of range");
  end

  logic signed [2*WIDTH-1:0] pctProd;
  logic signed [2*WIDTH-1:0] pctQuot;
  logic signed [WIDTH-1:0]   addSum;
  logic signed [WIDTH-1:0]   subDiff;
  logic signed [WIDTH-1:0]   targetNext;

  assign addSum  = refValue + ownValue;
  assign subDiff = refValue - ownValue;
  assign pctProd = refValue * ownValue;
  assign pctQuot = pctProd / (2*WIDTH)'(100);

  assign targetNext = (kind == WSE_KIND_ADD) ? addSum :
                      (kind == WSE_KIND_SUB) ? subDiff :
                      (kind == WSE_KIND_PCT) ? pctQuot[WIDTH-1:0] : ownValue;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      target <= '0;
    else
      target <= targetNext;
  end

endmodule

// ===== wse_setpoint_sva.sv
// checker: port-level properties of the weigh setpoint engine
`timescale 1ns/1ps
module wse_setpoint_sva
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  regAddr,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        sampleValid,
  input wire logic        outputSelectN,
  input wire logic        accumulatePulse,
  input wire logic        printPulse,
  input wire logic        tarePulse,
  input wire logic        stepDone
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ************************************************************
  // register port
  // ************************************************************
  property p_rdata_idle;
    !regRead |=> regRdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");

  property p_unmapped;
    regRead && regAddr == 8'h3C |=> regRdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");

  // ************************************************************
  // done actions and output
  // ************************************************************
  property p_acc_single;
    accumulatePulse |=> !accumulatePulse;
  endproperty
  a_acc_single: assert property (p_acc_single) else $error("accumulate pulse too long");

  property p_prn_single;
    printPulse |=> !printPulse;
  endproperty
  a_prn_single: assert property (p_prn_single) else $error("print pulse too long");

  property p_tare_single;
    tarePulse |=> !tarePulse;
  endproperty
  a_tare_single: assert property (p_tare_single) else $error("tare pulse too long");

  property p_done_single;
    stepDone |=> !stepDone;
  endproperty
  a_done_single: assert property (p_done_single) else $error("step done pulse too long");

  property p_out_fall;
    $fell(outputSelectN) |-> $past(sampleValid) || $past(regWrite) || $past(regWrite, 2);
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("output went active without cause");

  property p_out_rise;
    $rose(outputSelectN) |-> $past(sampleValid) || $past(regWrite) || $past(regWrite, 2);
  endproperty
  a_out_rise: assert property (p_out_rise) else $error("output released without cause");

  c_done: cover property (stepDone);
  c_tare: cover property (tarePulse);
  c_fall: cover property ($fell(outputSelectN));
endmodule

bind wse_setpoint wse_setpoint_sva i_wse_setpoint_sva
(
  .clk             (clk),
  .rst_n           (rst_n),
  .regAddr         (regAddr),
  .regWrite        (regWrite),
  .regRead         (regRead),
  .regRdata        (regRdata),
  .sampleValid     (sampleValid),
  .outputSelectN   (outputSelectN),
  .accumulatePulse (accumulatePulse),
  .printPulse      (printPulse),
  .tarePulse       (tarePulse),
  .stepDone        (stepDone)
);

// ===== wse_scale_model.sv
// partner model: measurement path delivering weight samples and standstill
`timescale 1ns/1ps
module wse_scale_model
(
  input  wire logic                             clk,
  output logic signed [wse_pkg::WEIGHT_W-1:0]   weightSample,
  output logic                                  sampleValid,
  output logic                                  standstill
);
  import wse_pkg::*;

  initial
  begin
    weightSample = 24'h00_0000;
    sampleValid  = 1'b0;
    standstill   = 1'b0;
  end

  task automatic send(input logic signed [WEIGHT_W-1:0] w, input logic s);
    @(posedge clk);
    weightSample <= w;
    sampleValid  <= 1'b1;
    standstill   <= s;
    @(posedge clk);
    sampleValid  <= 1'b0;
    // sample is not held once the strobe drops
    weightSample <= ~w;
  endtask
endmodule

// ===== testbench.sv
// testbench: scenario tasks for the weigh setpoint engine
`timescale 1ns/1ps
module testbench;
  import wse_pkg::*;

  logic clk = 1'b0;
  logic rst_n;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [31:0] regRdata;
  logic signed [WEIGHT_W-1:0] weightSample;
  logic sampleValid;
  logic standstill;
  logic outputSelectN;
  logic accumulatePulse;
  logic printPulse;
  logic tarePulse;
  logic stepDone;
  int errors = 0;
  int samples_checked = 0;
  int nAcc = 0;
  int nPrn = 0;
  int nTare = 0;
  int nDone = 0;

  always #5 clk = ~clk;

  wse_setpoint #(.WIDTH(WEIGHT_W), .SETTLE_UNIT(4)) i_wse_setpoint
  (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .weightSample(weightSample), .sampleValid(sampleValid),
    .standstill(standstill), .outputSelectN(outputSelectN), .accumulatePulse(accumulatePulse),
    .printPulse(printPulse), .tarePulse(tarePulse), .stepDone(stepDone)
  );

  wse_scale_model i_wse_scale_model
  (
    .clk(clk), .weightSample(weightSample), .sampleValid(sampleValid), .standstill(standstill)
  );

  always @(posedge clk)
  begin
    nAcc  += (accumulatePulse === 1'b1);
    nPrn  += (printPulse === 1'b1);
    nTare += (tarePulse === 1'b1);
    nDone += (stepDone === 1'b1);
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic wrap_up();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 check(name, regRdata, exp);
  endtask

  task automatic samp(input int w, input logic s, input logic expOut);
    i_wse_scale_model.send(w[WEIGHT_W-1:0], s);
    @(posedge clk);
    #1 check("outputSelectN", {31'h0000_0000, outputSelectN}, {31'h0000_0000, expOut});
  endtask

  task automatic wait_done();
    int n0;
    n0 = nDone;
    for (int i = 0; i < 200 && nDone == n0; i++)
      @(posedge clk);
    #1 check("stepDone count", nDone, n0 + 1);
    if (nDone == n0)
      wrap_up();
  endtask

  function automatic logic [31:0] mk(input logic [1:0] t, input logic [1:0] a, input logic [2:0] k,
    input logic b, input logic [1:0] ac, input logic [1:0] pr, input logic ta, input logic [2:0] r, input logic s);
    mk = {14'h0000, s, 1'b1, r, ta, pr, ac, b, k, a, t};
  endfunction

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset_values();
    rd_chk("tune", ADDR_TUNE, {RST_ADAPTIVE_LEARNING_INT, RST_SETTLE, RST_CORR_PCT});
    rd_chk("skew", ADDR_SKEW, 32'h0000_0000);
    rd_chk("unmapped", 8'h3C, 32'h0000_0000);
  endtask

  task automatic test_relative();
    wse_kind_e kinds[3] = '{WSE_KIND_ADD, WSE_KIND_SUB, WSE_KIND_PCT};
    int refs[3] = '{1, 7, 3};
    int owns[3] = '{200, 200, 50};
    int exps[3] = '{2200, 7800, 2000};
    for (int k = 0; k < 8; k++)
      reg_wr(ADDR_REFTAB + 8'(4 * k), 32'(1000 * (k + 1)));
    for (int i = 0; i < 3; i++)
    begin
      reg_wr(ADDR_VALUE, 32'(owns[i]));
      reg_wr(ADDR_CTRL, mk(WSE_TRIP_HIGHER, WSE_ANT_OFF, kinds[i], 1'b0, WSE_ACC_OFF, WSE_PRN_OFF, 1'b0,
        3'(refs[i]), 1'b0));
      repeat (3) @(posedge clk);
      rd_chk("target", ADDR_TARGET, 32'(exps[i]));
    end
  endtask

  task automatic test_continuous();
    int w[6] = '{900, 1010, 980, 1010, 940, 1010};
    logic o[6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    reg_wr(ADDR_VALUE, 32'd1000);
    reg_wr(ADDR_HYST, 32'd50);
    reg_wr(ADDR_CTRL, mk(WSE_TRIP_HIGHER, WSE_ANT_OFF, WSE_KIND_GROSS, 1'b0, WSE_ACC_OFF, WSE_PRN_OFF, 1'b0,
      3'd0, 1'b0));
    for (int i = 0; i < 6; i++)
      samp(w[i], 1'b0, o[i]);
  endtask

  task automatic test_batch_fixed();
    reg_wr(ADDR_TUNE, 32'h0100_0332);
    reg_wr(ADDR_ANTIC, 32'd100);
    reg_wr(ADDR_CTRL, mk(WSE_TRIP_HIGHER, WSE_ANT_FIXED, WSE_KIND_GROSS, 1'b1, WSE_ACC_QUIET, WSE_PRN_WAIT, 1'b1,
      3'd0, 1'b1));
    nAcc = 0;
    nPrn = 0;
    nTare = 0;
    samp(850, 1'b0, 1'b0);
    samp(910, 1'b0, 1'b1);
    repeat (3) @(posedge clk);
    #1 check("accumulate count", nAcc, 1);
    check("tare count", nTare, 1);
    check("print count", nPrn, 0);
    i_wse_scale_model.send(910, 1'b1);
    wait_done();
    repeat (2) @(posedge clk);
    #1 check("print count", nPrn, 1);
    rd_chk("antic", ADDR_ANTIC, 32'd100);
  endtask

  task automatic test_adaptive_learning();
    i_wse_scale_model.send(0, 1'b0);
    reg_wr(ADDR_TUNE, 32'h0100_0332);
    reg_wr(ADDR_ANTIC, 32'd100);
    reg_wr(ADDR_CTRL, mk(WSE_TRIP_HIGHER, WSE_ANT_ADAPTIVE_LEARNING, WSE_KIND_GROSS, 1'b1, WSE_ACC_OFF, WSE_PRN_OFF, 1'b0,
      3'd0, 1'b1));
    samp(850, 1'b0, 1'b0);
    samp(905, 1'b0, 1'b1);
    i_wse_scale_model.send(1020, 1'b1);
    wait_done();
    rd_chk("antic", ADDR_ANTIC, 32'd110);
    reg_wr(ADDR_CTRL, mk(WSE_TRIP_HIGHER, WSE_ANT_ADAPTIVE_LEARNING, WSE_KIND_GROSS, 1'b1, WSE_ACC_OFF, WSE_PRN_OFF, 1'b0,
      3'd0, 1'b1));
    samp(905, 1'b0, 1'b1);
    wait_done();
    rd_chk("antic", ADDR_ANTIC, 32'd110);
  endtask

  task automatic test_flow();
    reg_wr(ADDR_CTRL, mk(WSE_TRIP_HIGHER, WSE_ANT_FLOW, WSE_KIND_GROSS, 1'b1, WSE_ACC_OFF, WSE_PRN_OFF, 1'b0,
      3'd0, 1'b1));
    samp(850, 1'b0, 1'b0);
    samp(920, 1'b0, 1'b0);
    samp(960, 1'b0, 1'b1);
    wait_done();
    rd_chk("antic", ADDR_ANTIC, 32'd110);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    rst_n    = 1'b0;
    regAddr  = 8'h00;
    regWdata = 32'h0000_0000;
    regWrite = 1'b0;
    regRead  = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    test_reset_values();
    test_relative();
    test_continuous();
    test_batch_fixed();
    test_adaptive_learning();
    test_flow();
    wrap_up();
  end
endmodule
